// >>> rtl/wkc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wkc_consts.svh"

// Summary of operation
// - CRC preset zeros or ones by bit 30
// - Five pattern enables, disabled never matches
// - Link up-to-down sets link change flag
// - Link down-to-up sets link change flag
// - Wake frame raises power event if enabled
// - Wake packet raises power event if enabled
// - Link change raises power event if enabled
// - Wake frame sets sticky status bit 2
// - Wake packet sets sticky status bit 1
// - Link change sets sticky status bit 0
// - Status flags reset only by power-up reset, not by rst_b
// - Write one clears flag, otherwise read-only
// - Store: four mask words then control word
// - Control word: CRC high, offset low byte
// - Offset is eight bits, zero to 255
module wkc_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire wkc_pkg::wkc_rx_t rx,
    input wire logic link_up,
    input wire logic wake_packet_rx,
    output logic [4:0] pattern_match,
    output logic power_event_set,
    output logic irq
);

    // All checks share the system clock; either reset silences the top-level ones, rst_b alone the per-pattern ones
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b || !por_b);

    localparam int NUM_PAT = `WKC_NUM_PAT;
    localparam int WPP = `WKC_WORDS_PER_PAT;
    localparam int NWORDS = NUM_PAT * WPP;
    localparam logic [4:0] LAST_WORD = 5'(NWORDS - 1);

    // Address decode used by the register writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Bytewise CRC-16, MSB first
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[15] ^ d[i])
                r = {r[14:0], 1'b0} ^ `WKC_CRC_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        return r;
    endfunction

    // Control fields
    logic crc_preset_select;
    logic [NUM_PAT-1:0] pat_en; // Index 0 is pattern one
    logic link_down_detect_enable;
    logic link_up_detect_enable;
    logic wake_frame_event_enable;
    logic wake_packet_event_enable;
    logic link_change_event_enable;
    // Sticky wake flags, power-up reset domain
    logic wake_frame_seen;
    logic wake_packet_seen;
    logic link_change_seen;
    // Pattern store and its load pointer
    logic [31:0] store [NWORDS];
    logic [4:0] store_ptr;
    // Receive tracking
    logic [8:0] byte_cnt;
    wire [NUM_PAT-1:0] next_match;
    logic frame_hit;
    // Link tracking
    logic link_q;
    logic link_primed;
    logic link_evt;
    // Interrupt block
    logic [2:0] istat;
    logic [2:0] ien;
    logic [31:0] next_rdata;

    // Decoded strobes
    logic wr_ctl;
    logic wr_pat;
    assign wr_ctl = ce && reg_wr && hit(reg_addr, `WKC_OFS_CTL);
    assign wr_pat = ce && reg_wr && hit(reg_addr, `WKC_OFS_PAT);

    // Link edges, gated by the two detect enables
    logic link_rise;
    logic link_fall;
    assign link_rise = link_primed && link_up && !link_q && link_up_detect_enable;
    assign link_fall = link_primed && !link_up && link_q && link_down_detect_enable;

    // Control register; reset value all zero
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crc_preset_select <= 1'b0;
            pat_en <= '0;
            link_down_detect_enable <= 1'b0;
            link_up_detect_enable <= 1'b0;
            wake_frame_event_enable <= 1'b0;
            wake_packet_event_enable <= 1'b0;
            link_change_event_enable <= 1'b0;
        end
        else if (wr_ctl)
        begin
            crc_preset_select <= reg_wdata[`WKC_BIT_CRC_SEL];
            // Enables sit from bit 29 downward, pattern one first
            for (int p = 0; p < NUM_PAT; p++)
            begin
                pat_en[p] <= reg_wdata[`WKC_BIT_PEN_HI - p];
            end
            link_down_detect_enable <= reg_wdata[`WKC_BIT_LDOWN];
            link_up_detect_enable <= reg_wdata[`WKC_BIT_LUP];
            wake_frame_event_enable <= reg_wdata[`WKC_BIT_FRM_EVT];
            wake_packet_event_enable <= reg_wdata[`WKC_BIT_PKT_EVT];
            link_change_event_enable <= reg_wdata[`WKC_BIT_LNK_EVT];
        end
    end

    // Sticky flags live on power-up reset so an ordinary reset keeps wake cause
    always_ff @(posedge clk_sys or negedge por_b)
    begin
        if (!por_b)
        begin
            wake_frame_seen <= 1'b0;
            wake_packet_seen <= 1'b0;
            link_change_seen <= 1'b0;
        end
        else if (ce)
        begin
            // A set in the clearing cycle wins, so no event is lost
            wake_frame_seen <= frame_hit
                || (wake_frame_seen && !(wr_ctl && reg_wdata[`WKC_BIT_FRM_FLAG]));
            wake_packet_seen <= wake_packet_rx
                || (wake_packet_seen && !(wr_ctl && reg_wdata[`WKC_BIT_PKT_FLAG]));
            link_change_seen <= link_evt
                || (link_change_seen && !(wr_ctl && reg_wdata[`WKC_BIT_LNK_FLAG]));
        end
    end

    // Pattern store loader; software must stream all words in table order
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            store_ptr <= 5'h00;
            for (int w = 0; w < NWORDS; w++)
            begin
                store[w] <= 32'h0000_0000;
            end
        end
        else if (wr_pat)
        begin
            store[store_ptr] <= reg_wdata;
            // Wrap keeps a repeated full load aligned
            if (store_ptr == LAST_WORD)
                store_ptr <= 5'h00;
            else
                store_ptr <= store_ptr + 5'h01;
        end
    end

    // Byte position in the current frame, saturating past any window
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            byte_cnt <= 9'h000;
        else if (ce && rx.valid)
        begin
            if (rx.sof)
                byte_cnt <= 9'h001;
            else if (byte_cnt != `WKC_CNT_MAX)
                byte_cnt <= byte_cnt + 9'h001;
        end
    end

    logic [8:0] pos;
    logic [15:0] preset;
    assign pos = rx.sof ? 9'h000 : byte_cnt;
    assign preset = crc_preset_select ? `WKC_CRC_ONES : `WKC_CRC_ZERO;

    // One CRC engine per pattern
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAT; gp++)
        begin : g_pat
            localparam int B = gp * WPP;
            logic [127:0] mask;
            logic [7:0] ofs;
            logic [15:0] want;
            logic [8:0] rel;
            logic sel;
            logic [15:0] base;
            logic [15:0] next_crc;
            logic [15:0] crc_acc;
            // Four mask words, then CRC high half and offset low byte
            assign mask = {store[B+3], store[B+2], store[B+1], store[B]};
            assign want = store[B+4][31:16];
            assign ofs = store[B+4][7:0];
            assign rel = pos - {1'b0, ofs};
            // Only bytes inside the 128-byte window with mask set feed the CRC
            assign sel = (pos >= {1'b0, ofs}) && (rel < `WKC_MASK_BITS)
                && mask[rel[6:0]];
            assign base = rx.sof ? preset : crc_acc;
            assign next_crc = sel ? crc16_byte(base, rx.data) : base;
            assign next_match[gp] = ce && rx.valid && rx.eof && pat_en[gp]
                && (next_crc == want);

            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                    crc_acc <= `WKC_CRC_ZERO;
                else if (ce && rx.valid)
                    crc_acc <= next_crc;
            end

            // A frozen clock enable holds the last pulse, so only live cycles count
            chk_pat_disabled: assert property (@(posedge clk_sys) disable iff (!rst_b)
                ce && !pat_en[gp] |=> !pattern_match[gp])
                else $error("disabled pattern reported a match");
            chk_crc_preset: assert property (@(posedge clk_sys) disable iff (!rst_b)
                ce && rx.valid && rx.sof && !sel
                |=> crc_acc == ($past(crc_preset_select) ? 16'hffff : 16'h0000))
                else $error("crc accumulator did not take preset");
        end
    endgenerate

    // Match pulses and frame hit
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pattern_match <= 5'h00;
            frame_hit <= 1'b0;
        end
        else if (ce)
        begin
            pattern_match <= next_match;
            frame_hit <= |next_match;
        end
    end

    // Link sampler; first sample after reset only primes, it is no edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link_q <= 1'b0;
            link_primed <= 1'b0;
            link_evt <= 1'b0;
        end
        else if (ce)
        begin
            link_q <= link_up;
            link_primed <= 1'b1;
            link_evt <= link_rise || link_fall;
        end
    end

    // Power event pulse towards the power management status register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            power_event_set <= 1'b0;
        else if (ce)
            power_event_set <= (frame_hit && wake_frame_event_enable)
                || (wake_packet_rx && wake_packet_event_enable)
                || (link_evt && link_change_event_enable);
    end

    // Interrupt status: sticky, write-one clear, set wins
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            istat <= 3'h0;
            ien <= 3'h0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            istat <= {frame_hit, wake_packet_rx, link_evt}
                | (istat & ~((reg_wr && hit(reg_addr, `WKC_OFS_ICLR)) ? reg_wdata[2:0] : 3'h0));
            if (reg_wr && hit(reg_addr, `WKC_OFS_IEN))
                ien <= reg_wdata[2:0];
            // One cycle behind status; keeps the pin straight from a flop
            irq <= |(istat & ien);
        end
    end

    // Read mux; write-only and unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            `WKC_OFS_CTL:
            begin
                next_rdata[`WKC_BIT_CRC_SEL] = crc_preset_select;
                for (int p = 0; p < NUM_PAT; p++)
                begin
                    next_rdata[`WKC_BIT_PEN_HI - p] = pat_en[p];
                end
                next_rdata[`WKC_BIT_LDOWN] = link_down_detect_enable;
                next_rdata[`WKC_BIT_LUP] = link_up_detect_enable;
                next_rdata[`WKC_RSV_LO +: 5] = `WKC_RSV_VAL;
                next_rdata[`WKC_BIT_FRM_EVT] = wake_frame_event_enable;
                next_rdata[`WKC_BIT_PKT_EVT] = wake_packet_event_enable;
                next_rdata[`WKC_BIT_LNK_EVT] = link_change_event_enable;
                next_rdata[`WKC_BIT_FRM_FLAG] = wake_frame_seen;
                next_rdata[`WKC_BIT_PKT_FLAG] = wake_packet_seen;
                next_rdata[`WKC_BIT_LNK_FLAG] = link_change_seen;
            end
            `WKC_OFS_ISTAT: next_rdata[2:0] = istat;
            `WKC_OFS_IEN: next_rdata[2:0] = ien;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (ce)
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end

    chk_ptr_wrap: assert property (wr_pat && store_ptr == 5'h18 |=> store_ptr == 5'h00)
        else $error("store pointer did not wrap after last word");
    chk_ptr_step: assert property (wr_pat && store_ptr < 5'h18
        |=> store_ptr == $past(store_ptr) + 5'h01)
        else $error("store pointer did not advance");
    chk_frame_flag: assert property (ce && frame_hit |=> wake_frame_seen)
        else $error("wake frame flag not set");
    chk_packet_flag: assert property (ce && wake_packet_rx |=> wake_packet_seen)
        else $error("wake packet flag not set");
    chk_link_flag: assert property (ce && link_evt |=> link_change_seen)
        else $error("link change flag not set");
    chk_flag_clear: assert property (wr_ctl && reg_wdata[2] && !frame_hit
        |=> !wake_frame_seen)
        else $error("write one did not clear wake frame flag");
    chk_flag_sticky: assert property (wake_frame_seen && !wr_ctl |=> wake_frame_seen)
        else $error("wake frame flag dropped by itself");
    chk_link_rise: assert property (ce && link_rise |=> ##1 link_change_seen)
        else $error("link up edge not recorded");
    chk_link_fall: assert property (ce && link_fall |=> ##1 link_change_seen)
        else $error("link down edge not recorded");
    chk_pme_frame: assert property (ce && frame_hit && wake_frame_event_enable
        |=> power_event_set)
        else $error("frame event did not raise power event");
    chk_pme_packet: assert property (ce && wake_packet_rx && wake_packet_event_enable
        |=> power_event_set)
        else $error("wake packet did not raise power event");
    chk_pme_link: assert property (ce && link_evt && link_change_event_enable
        |=> power_event_set)
        else $error("link event did not raise power event");

    cov_pat_match: cover property (|pattern_match);
    cov_ptr_wrap: cover property (wr_pat && store_ptr == 5'h18);
    cov_power_evt: cover property (power_event_set);
    cov_irq: cover property (irq);

endmodule
`default_nettype wire

// >>> rtl/wkc_consts.svh
`ifndef WKC_CONSTS_SVH
`define WKC_CONSTS_SVH
// Register byte offsets
`define WKC_OFS_CTL 8'h68
`define WKC_OFS_PAT 8'h70
`define WKC_OFS_ISTAT 8'h90
`define WKC_OFS_ICLR 8'h94
`define WKC_OFS_IEN 8'h98
// Control/status field positions
`define WKC_BIT_CRC_SEL 30
`define WKC_BIT_PEN_HI 29
`define WKC_BIT_LDOWN 17
`define WKC_BIT_LUP 16
`define WKC_BIT_FRM_EVT 10
`define WKC_BIT_PKT_EVT 9
`define WKC_BIT_LNK_EVT 8
`define WKC_BIT_FRM_FLAG 2
`define WKC_BIT_PKT_FLAG 1
`define WKC_BIT_LNK_FLAG 0
// Reserved field 15:11 reads back a fixed value
`define WKC_RSV_LO 11
`define WKC_RSV_VAL 5'h01
// CRC-16 presets and generator
`define WKC_CRC_ZERO 16'h0000
`define WKC_CRC_ONES 16'hffff
`define WKC_CRC_POLY 16'h8005
// Pattern store geometry
`define WKC_NUM_PAT 5
`define WKC_WORDS_PER_PAT 5
`define WKC_MASK_BITS 9'h080
`define WKC_CNT_MAX 9'h1ff
`endif

// >>> rtl/wkc_pkg.sv
`default_nettype none
package wkc_pkg;
    // One received byte with its frame markers
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } wkc_rx_t;
endpackage
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int FLEN = 260; // Frame length, reaches past offset 255
    localparam logic [31:0] RSV = 32'h0000_0800; // Reserved field reads 5'h01
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    wkc_pkg::wkc_rx_t rx = '0;
    logic link_up = 1'b0;
    logic wake_packet_rx = 1'b0;
    logic [4:0] pattern_match;
    logic power_event_set;
    logic irq;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [4:0] em;
    // Bench image of the pattern store
    logic [127:0] pmask [5];
    logic [7:0] poff [5];
    logic [15:0] pcrc [5];
    // One row: clock enable, write first, address, write data, read-back value
    typedef struct packed {
        logic ce;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } wkc_row_t;
    wkc_row_t rows [8] = '{
        '{1'b1, 1'b1, 8'h68, 32'hffff_ffff, 32'h7e03_0f00},
        '{1'b0, 1'b1, 8'h68, 32'h0000_0000, 32'h7e03_0f00},
        '{1'b1, 1'b1, 8'h68, 32'h0000_0000, 32'h0000_0800},
        '{1'b1, 1'b1, 8'h98, 32'hffff_ffff, 32'h0000_0007},
        '{1'b1, 1'b0, 8'h70, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 1'b1, 8'h94, 32'hffff_ffff, 32'h0000_0000},
        '{1'b1, 1'b1, 8'h3c, 32'hffff_ffff, 32'h0000_0000},
        '{1'b1, 1'b0, 8'h90, 32'h0000_0000, 32'h0000_0000}};

    wkc_top i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .por_b(por_b),
        .ce(ce),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .rx(rx),
        .link_up(link_up),
        .wake_packet_rx(wake_packet_rx),
        .pattern_match(pattern_match),
        .power_event_set(power_event_set),
        .irq(irq)
    );

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // Single write; an idle edge follows so strobes never double up
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read; data sampled mid-cycle after the strobe edge, its only valid cycle
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd = reg_rdata;
        check($sformatf("reg %h", a), exp, rd);
        @(posedge clk_sys);
    endtask
    // Bit-serial reference, data bit 7 first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        return r;
    endfunction
    // Masked CRC of the bench frame, whose byte k carries the low eight bits of k
    function automatic logic [15:0] pat_crc(input int p, input logic [15:0] preset);
        logic [15:0] r;
        r = preset;
        for (int k = 0; k < FLEN; k++)
            if (k >= poff[p] && k - poff[p] < 128 && pmask[p][k - poff[p]])
                r = crc_byte(r, k[7:0]);
        return r;
    endfunction
    function automatic logic [4:0] exp_match(input logic [4:0] en, input logic [15:0] preset);
        for (int p = 0; p < 5; p++)
            exp_match[p] = en[p] && (pat_crc(p, preset) === pcrc[p]);
    endfunction
    // Full store load; junk fills every word with ones
    task automatic load_store(input logic junk);
        for (int p = 0; p < 5; p++)
        begin
            for (int w = 0; w < 4; w++)
                reg_write(8'h70, junk ? 32'hffff_ffff : pmask[p][32 * w +: 32]);
            reg_write(8'h70, junk ? 32'hffff_ffff : {pcrc[p], 8'h00, poff[p]});
        end
    endtask
    // One frame, then the match pulse and the power event pulse a cycle apart
    task automatic send_frame(input logic [4:0] exp_pm, input logic exp_pe);
        for (int k = 0; k < FLEN; k++)
        begin
            rx <= {1'b1, k == 0, k == FLEN - 1, k[7:0]};
            @(posedge clk_sys);
        end
        rx <= '0;
        @(negedge clk_sys);
        check("pattern_match", {27'h0, exp_pm}, {27'h0, pattern_match});
        @(negedge clk_sys);
        check("power_event_set", {31'h0, exp_pe}, {31'h0, power_event_set});
        @(posedge clk_sys);
    endtask
    // Link transition under a given control word; flag is cleared afterwards
    task automatic link_case(input logic [31:0] ctl, input logic lvl, input logic fl,
                             input logic pe);
        reg_write(8'h68, ctl);
        link_up <= lvl;
        // Edge seen at the first clock, event pulse stands after the second
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("power_event_set", {31'h0, pe}, {31'h0, power_event_set});
        @(posedge clk_sys);
        expect_reg(8'h68, ctl | RSV | {31'h0, fl});
        reg_write(8'h68, ctl | 32'h0000_0001);
    endtask
    // Verdict and end of run
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        finish_test();
    end

    initial
    begin
        pmask = '{128'h3, 128'h1 << 127, 128'h0, 128'h3, 128'h1};
        poff = '{8'h02, 8'h00, 8'h00, 8'h02, 8'hff};
        pcrc[0] = pat_crc(0, 16'h0000);
        pcrc[1] = pat_crc(1, 16'hffff);
        pcrc[2] = 16'h1234;
        pcrc[3] = pat_crc(3, 16'h0000) ^ 16'h0001;
        pcrc[4] = pat_crc(4, 16'h0000);
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge clk_sys);
        expect_reg(8'h68, RSV);
        // Register map rows
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                ce <= rows[i].ce;
                reg_write(rows[i].addr, rows[i].wdata);
                ce <= 1'b1;
            end
            expect_reg(rows[i].addr, rows[i].exp);
        end
        // Link transitions, each direction with and without its detect enable
        link_case(32'h0001_0100, 1'b1, 1'b1, 1'b1);
        link_case(32'h0001_0100, 1'b0, 1'b0, 1'b0);
        link_case(32'h0002_0100, 1'b1, 1'b0, 1'b0);
        link_case(32'h0002_0100, 1'b0, 1'b1, 1'b1);
        link_case(32'h0001_0000, 1'b1, 1'b1, 1'b0);
        // Remote wake packet with interrupt raise, mask and clear
        reg_write(8'h94, 32'h0000_0007);
        reg_write(8'h68, 32'h0000_0201);
        expect_reg(8'h90, 32'h0000_0000);
        wake_packet_rx <= 1'b1;
        @(posedge clk_sys);
        wake_packet_rx <= 1'b0;
        // Power event pulse stands in the cycle right after the packet edge
        @(negedge clk_sys);
        check("power_event_set", 32'h1, {31'h0, power_event_set});
        @(negedge clk_sys);
        check("irq", 32'h1, {31'h0, irq});
        @(posedge clk_sys);
        expect_reg(8'h68, 32'h0000_0a02);
        expect_reg(8'h90, 32'h0000_0002);
        reg_write(8'h98, 32'h0000_0001);
        @(negedge clk_sys);
        check("irq", 32'h0, {31'h0, irq});
        @(posedge clk_sys);
        reg_write(8'h98, 32'h0000_0007);
        reg_write(8'h94, 32'h0000_0002);
        expect_reg(8'h90, 32'h0000_0000);
        // Flags ignore a zero write and ordinary reset, only power-up reset clears
        reg_write(8'h68, 32'h0000_0000);
        expect_reg(8'h68, 32'h0000_0802);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        expect_reg(8'h68, 32'h0000_0802);
        por_b <= 1'b0;
        @(posedge clk_sys);
        por_b <= 1'b1;
        @(posedge clk_sys);
        expect_reg(8'h68, RSV);
        // Junk load then real load: wrong placement if the pointer fails to wrap
        load_store(1'b1);
        load_store(1'b0);
        reg_write(8'h68, 32'h3e00_0400);
        em = exp_match(5'h1f, 16'h0000);
        check("match expected", 32'h0000_0011, {27'h0, em});
        send_frame(em, |em);
        expect_reg(8'h68, 32'h3e00_0c04);
        reg_write(8'h68, 32'h7000_0000);
        em = exp_match(5'h03, 16'hffff);
        check("match expected", 32'h0000_0002, {27'h0, em});
        send_frame(em, 1'b0);
        expect_reg(8'h68, 32'h7000_0804);
        finish_test();
    end
endmodule
`default_nettype wire
